// *** verilog/srd_pkg.sv ***
// Constants and types for the read descriptor decoder
// What this block does
// - Opcode 08h reads count blocks from address
// - Six-byte form: length zero means 256 blocks
// - Opcode 28h: address bytes 2-5, count 7-8
// - Opcode A8h: count bytes 6-9, else as ten-byte
// - Opcode 88h: address 2-9, count 10-13
// - Non-volatile force-access bit accepted and ignored
// - Disable-page-out hint bit is ignored
// - Force-unit-access bit ignored in longer forms
// - Unprotected medium, nonzero protect code: invalid field
// - Protect code 000b: no info sent, no checks
// - Codes 001b-100b: append protection info to data
// - Guard checked only for 001b and 100b
// - Reference tag checked only for 001b, 010b
// - Application tag never checked in these forms
// - Code 011b: send info, skip all checks
// - Codes 101b-111b rejected: invalid field in descriptor
// - Failed enabled check: aborted command, field code
// - Zero count, longer forms: good status, no data
// - Zero count with read-ahead on starts read-ahead
package srd_pkg;
   // Opcodes of the four read forms
   localparam logic [7:0] OP_READ6 = 8'h08;
   localparam logic [7:0] OP_READ10 = 8'h28;
   localparam logic [7:0] OP_READ12 = 8'hA8;
   localparam logic [7:0] OP_READ16 = 8'h88;
   // Protection codes
   localparam logic [2:0] RDP_NONE = 3'h0;
   localparam logic [2:0] RDP_ALL = 3'h1;
   localparam logic [2:0] RDP_NO_GUARD = 3'h2;
   localparam logic [2:0] RDP_GUARD_ONLY = 3'h4;
   localparam logic [2:0] RDP_MAX_VALID = 3'h4;
   // Byte 1 field positions
   localparam int RDP_MSB = 7;
   localparam int RDP_LSB = 5;
   localparam int DPO_BIT = 4;
   localparam int FUA_BIT = 3;
   localparam int FUA_NV_BIT = 1;
   localparam int LBA6_MSB = 4;
   localparam logic [31:0] LEN6_ZERO_BLOCKS = 32'h0000_0100;
   // Status, sense keys, additional codes
   localparam logic [7:0] ST_GOOD = 8'h00;
   localparam logic [7:0] ST_CHECK = 8'h02;
   localparam logic [3:0] SK_NONE = 4'h0;
   localparam logic [3:0] SK_ILLEGAL = 4'h5;
   localparam logic [3:0] SK_ABORTED = 4'hB;
   localparam logic [7:0] ASC_NONE = 8'h00;
   localparam logic [7:0] ASC_INV_OPCODE = 8'h20;
   localparam logic [7:0] ASC_INV_FIELD = 8'h24;
   localparam logic [7:0] ASC_PI_FAIL = 8'h10;
   localparam logic [7:0] ASCQ_NONE = 8'h00;
   localparam logic [7:0] ASCQ_GUARD = 8'h01;
   localparam logic [7:0] ASCQ_REF = 8'h03;
   // Register byte addresses
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_CDB0 = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_CDB1 = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_CDB2 = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_CDB3 = 8'h0C;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h14;
   localparam logic [ADDR_W-1:0] ADDR_SENSE = 8'h18;
   localparam logic [ADDR_W-1:0] ADDR_LBA_LO = 8'h1C;
   localparam logic [ADDR_W-1:0] ADDR_LBA_HI = 8'h20;
   localparam logic [ADDR_W-1:0] ADDR_COUNT = 8'h24;
   localparam logic [ADDR_W-1:0] ADDR_FLAGS = 8'h28;
   localparam int CDB_BYTES = 16;
   // Register field positions
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_PIFMT_BIT = 1;
   localparam int CTRL_RAHEAD_BIT = 2;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_CODE_LSB = 8;
   localparam int STAT_KEY_LSB = 16;
   localparam int SENSE_ASC_LSB = 8;
   localparam int FLG_SENDPI_BIT = 0;
   localparam int FLG_GUARD_BIT = 1;
   localparam int FLG_REF_BIT = 2;
   localparam int FLG_APP_BIT = 3;
   localparam int FLG_OPC_LSB = 8;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Command sequencer states
   typedef enum logic [1:0] {
      SRD_IDLE,
      SRD_DECODE,
      SRD_ISSUE,
      SRD_WAIT
   } srd_state_type;
endpackage

// *** verilog/srd_read_cdb_decoder.sv ***
// Read descriptor decoder with AXI4-Lite registers and a data path request port
`timescale 1ns/100ps
`default_nettype none
module srd_read_cdb_decoder (
   input wire logic mclk_i, // 250 MHz clock
   input wire logic rst_i, // Async reset, high
   input wire logic [srd_pkg::ADDR_W-1:0] s_axi_awaddr_i, // Write address
   input wire logic s_axi_awvalid_i, // Write address valid
   output logic s_axi_awready_o, // Write address ready
   input wire logic [31:0] s_axi_wdata_i, // Write data
   input wire logic [3:0] s_axi_wstrb_i, // Byte enables
   input wire logic s_axi_wvalid_i, // Write data valid
   output logic s_axi_wready_o, // Write data ready
   output logic [1:0] s_axi_bresp_o, // Write response
   output logic s_axi_bvalid_o, // Write response valid
   input wire logic s_axi_bready_i, // Write response ready
   input wire logic [srd_pkg::ADDR_W-1:0] s_axi_araddr_i, // Read address
   input wire logic s_axi_arvalid_i, // Read address valid
   output logic s_axi_arready_o, // Read address ready
   output logic [31:0] s_axi_rdata_o, // Read data
   output logic [1:0] s_axi_rresp_o, // Read response
   output logic s_axi_rvalid_o, // Read data valid
   input wire logic s_axi_rready_i, // Read data ready
   output logic xfer_valid_o, // Block read request valid
   input wire logic xfer_ready_i, // Data path takes request
   output logic [63:0] xfer_lba_o, // First block address
   output logic [31:0] xfer_count_o, // Blocks to move
   output logic xfer_send_pi_o, // Append protection info
   output logic xfer_chk_guard_o, // Verify guard field
   output logic xfer_chk_ref_o, // Verify reference tag
   output logic xfer_chk_app_o, // Verify application tag
   input wire logic xfer_done_i, // Data path finished, pulse
   input wire logic xfer_guard_err_i, // Guard mismatch seen
   input wire logic xfer_ref_err_i, // Reference tag mismatch seen
   output logic read_ahead_o // Start read-ahead, pulse
);
   import srd_pkg::*;

   typedef struct packed {
      srd_state_type state;
      logic [CDB_BYTES-1:0][7:0] cdb;
      logic pi_fmt;
      logic ra_en;
      logic done;
      logic [7:0] stat_code;
      logic [3:0] sense_key;
      logic [7:0] asc;
      logic [7:0] ascq;
      logic [63:0] lba;
      logic [31:0] count;
      logic send_pi;
      logic chk_g;
      logic chk_r;
      logic [7:0] opcode;
      logic ra_pulse;
      logic aw_got;
      logic [ADDR_W-1:0] awaddr;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } srd_regs_type;

   srd_regs_type s;
   srd_regs_type next_s;

   ////////////////////////////////////////////////////////////////////////
   // Byte-enable merge of a written word into a stored one
   function automatic logic [31:0] srd_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                             input logic [3:0] strb);
      logic [31:0] res;
      res = old_w;
      for (int j = 0; j < 4; j++) begin
         if (strb[j]) begin
            res[8*j +: 8] = new_w[8*j +: 8];
         end
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Handshake outputs straight from state
   assign s_axi_awready_o = !s.aw_got && !s.bvalid;
   assign s_axi_wready_o = !s.w_got && !s.bvalid;
   assign s_axi_arready_o = !s.rvalid;
   assign s_axi_bvalid_o = s.bvalid;
   assign s_axi_bresp_o = s.bresp;
   assign s_axi_rvalid_o = s.rvalid;
   assign s_axi_rdata_o = s.rdata;
   assign s_axi_rresp_o = s.rresp;
   assign xfer_valid_o = (s.state == SRD_ISSUE);
   assign xfer_lba_o = s.lba;
   assign xfer_count_o = s.count;
   assign xfer_send_pi_o = s.send_pi;
   assign xfer_chk_guard_o = s.chk_g;
   assign xfer_chk_ref_o = s.chk_r;
   assign xfer_chk_app_o = 1'b0; // Only the 32-byte form checks it
   assign read_ahead_o = s.ra_pulse;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic: bus slave, decoder and sequencer
   always_comb begin
      logic [7:0] op;
      logic [7:0] b1;
      logic [2:0] rdp;
      logic known;
      logic long_form;
      logic [63:0] d_lba;
      logic [31:0] d_count;
      logic [31:0] word;
      logic start;
      int widx;
      next_s = s;
      op = s.cdb[0];
      b1 = s.cdb[1];
      rdp = RDP_NONE;
      known = 1'b1;
      long_form = 1'b1;
      d_lba = '0;
      d_count = '0;
      word = '0;
      start = 1'b0;
      widx = 0;
      next_s.ra_pulse = 1'b0;

      // Address and data may come in either order
      if (s_axi_awvalid_i && s_axi_awready_o) begin
         next_s.aw_got = 1'b1;
         next_s.awaddr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
         next_s.w_got = 1'b1;
         next_s.wdata = s_axi_wdata_i;
         next_s.wstrb = s_axi_wstrb_i;
      end
      if (s.bvalid && s_axi_bready_i) begin
         next_s.bvalid = 1'b0;
      end

      // Register write once both halves are held
      if (s.aw_got && s.w_got && !s.bvalid) begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = RESP_OKAY;
         unique case (s.awaddr)
            ADDR_CDB0, ADDR_CDB1, ADDR_CDB2, ADDR_CDB3: begin
               // Descriptor is frozen while a command runs
               widx = int'(s.awaddr[ADDR_W-1:2]);
               if (s.state == SRD_IDLE) begin
                  word = srd_merge({s.cdb[4*widx+3], s.cdb[4*widx+2], s.cdb[4*widx+1], s.cdb[4*widx]},
                                   s.wdata, s.wstrb);
                  for (int j = 0; j < 4; j++) begin
                     next_s.cdb[4*widx+j] = word[8*j +: 8];
                  end
               end
            end
            ADDR_CTRL: begin
               if (s.wstrb[0]) begin
                  next_s.pi_fmt = s.wdata[CTRL_PIFMT_BIT];
                  next_s.ra_en = s.wdata[CTRL_RAHEAD_BIT];
                  start = s.wdata[CTRL_START_BIT];
               end
            end
            ADDR_STATUS, ADDR_SENSE, ADDR_LBA_LO, ADDR_LBA_HI, ADDR_COUNT, ADDR_FLAGS: begin
               // Read-only words accept and drop the write
            end
            default: begin
               next_s.bresp = RESP_SLVERR;
            end
         endcase
      end

      // Register read
      if (s.rvalid && s_axi_rready_i) begin
         next_s.rvalid = 1'b0;
      end
      if (s_axi_arvalid_i && s_axi_arready_o) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = RESP_OKAY;
         next_s.rdata = '0;
         unique case (s_axi_araddr_i)
            ADDR_CDB0: next_s.rdata = {s.cdb[3], s.cdb[2], s.cdb[1], s.cdb[0]};
            ADDR_CDB1: next_s.rdata = {s.cdb[7], s.cdb[6], s.cdb[5], s.cdb[4]};
            ADDR_CDB2: next_s.rdata = {s.cdb[11], s.cdb[10], s.cdb[9], s.cdb[8]};
            ADDR_CDB3: next_s.rdata = {s.cdb[15], s.cdb[14], s.cdb[13], s.cdb[12]};
            ADDR_CTRL: begin
               next_s.rdata[CTRL_PIFMT_BIT] = s.pi_fmt;
               next_s.rdata[CTRL_RAHEAD_BIT] = s.ra_en;
            end
            ADDR_STATUS: begin
               next_s.rdata[STAT_BUSY_BIT] = (s.state != SRD_IDLE);
               next_s.rdata[STAT_DONE_BIT] = s.done;
               next_s.rdata[STAT_CODE_LSB +: 8] = s.stat_code;
               next_s.rdata[STAT_KEY_LSB +: 4] = s.sense_key;
            end
            ADDR_SENSE: next_s.rdata = {16'h0000, s.asc, s.ascq};
            ADDR_LBA_LO: next_s.rdata = s.lba[31:0];
            ADDR_LBA_HI: next_s.rdata = s.lba[63:32];
            ADDR_COUNT: next_s.rdata = s.count;
            ADDR_FLAGS: begin
               next_s.rdata[FLG_SENDPI_BIT] = s.send_pi;
               next_s.rdata[FLG_GUARD_BIT] = s.chk_g;
               next_s.rdata[FLG_REF_BIT] = s.chk_r;
               next_s.rdata[FLG_APP_BIT] = 1'b0;
               next_s.rdata[FLG_OPC_LSB +: 8] = s.opcode;
            end
            default: next_s.rresp = RESP_SLVERR;
         endcase
      end

      // Field extraction per form; hint bits are never looked at
      unique case (op)
         OP_READ6: begin
            long_form = 1'b0;
            d_lba = {43'h0, b1[LBA6_MSB:0], s.cdb[2], s.cdb[3]};
            d_count = (s.cdb[4] == 8'h00) ? LEN6_ZERO_BLOCKS : {24'h0, s.cdb[4]};
         end
         OP_READ10: begin
            d_lba = {32'h0, s.cdb[2], s.cdb[3], s.cdb[4], s.cdb[5]};
            d_count = {16'h0, s.cdb[7], s.cdb[8]};
         end
         OP_READ12: begin
            d_lba = {32'h0, s.cdb[2], s.cdb[3], s.cdb[4], s.cdb[5]};
            d_count = {s.cdb[6], s.cdb[7], s.cdb[8], s.cdb[9]};
         end
         OP_READ16: begin
            d_lba = {s.cdb[2], s.cdb[3], s.cdb[4], s.cdb[5],
                     s.cdb[6], s.cdb[7], s.cdb[8], s.cdb[9]};
            d_count = {s.cdb[10], s.cdb[11], s.cdb[12], s.cdb[13]};
         end
         default: begin
            known = 1'b0;
         end
      endcase
      if (long_form) begin
         rdp = b1[RDP_MSB:RDP_LSB];
      end

      // Command sequencer
      unique case (s.state)
         SRD_IDLE: begin
            if (start) begin
               next_s.state = SRD_DECODE;
               next_s.done = 1'b0;
            end
         end
         SRD_DECODE: begin
            next_s.opcode = op;
            next_s.lba = d_lba;
            next_s.count = d_count;
            next_s.send_pi = (rdp != RDP_NONE);
            next_s.chk_g = (rdp == RDP_ALL) || (rdp == RDP_GUARD_ONLY);
            next_s.chk_r = (rdp == RDP_ALL) || (rdp == RDP_NO_GUARD);
            next_s.stat_code = ST_CHECK;
            next_s.sense_key = SK_ILLEGAL;
            next_s.asc = ASC_INV_FIELD;
            next_s.ascq = ASCQ_NONE;
            if (!known) begin
               // Rejected before any request reaches the data path
               next_s.asc = ASC_INV_OPCODE;
               next_s.state = SRD_IDLE;
               next_s.done = 1'b1;
            end else if (rdp > RDP_MAX_VALID) begin
               next_s.state = SRD_IDLE;
               next_s.done = 1'b1;
            end else if (!s.pi_fmt && (rdp != RDP_NONE)) begin
               next_s.state = SRD_IDLE;
               next_s.done = 1'b1;
            end else if (d_count == 32'h0000_0000) begin
               // Only longer forms reach here; no data, good status
               next_s.stat_code = ST_GOOD;
               next_s.sense_key = SK_NONE;
               next_s.asc = ASC_NONE;
               next_s.ra_pulse = s.ra_en;
               next_s.state = SRD_IDLE;
               next_s.done = 1'b1;
            end else begin
               next_s.state = SRD_ISSUE;
            end
         end
         SRD_ISSUE: begin
            if (xfer_ready_i) begin
               next_s.state = SRD_WAIT;
            end
         end
         SRD_WAIT: begin
            if (xfer_done_i) begin
               // Errors count only for checks that were enabled; guard reported first
               next_s.state = SRD_IDLE;
               next_s.done = 1'b1;
               next_s.stat_code = ST_GOOD;
               next_s.sense_key = SK_NONE;
               next_s.asc = ASC_NONE;
               next_s.ascq = ASCQ_NONE;
               if (s.chk_g && xfer_guard_err_i) begin
                  next_s.stat_code = ST_CHECK;
                  next_s.sense_key = SK_ABORTED;
                  next_s.asc = ASC_PI_FAIL;
                  next_s.ascq = ASCQ_GUARD;
               end else if (s.chk_r && xfer_ref_err_i) begin
                  next_s.stat_code = ST_CHECK;
                  next_s.sense_key = SK_ABORTED;
                  next_s.asc = ASC_PI_FAIL;
                  next_s.ascq = ASCQ_REF;
               end
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule // srd_read_cdb_decoder
`default_nettype wire

// *** bench/srd_read_cdb_decoder_props.sv ***
// Concurrent checks on the decoder top-level ports
`timescale 1ns/100ps
`default_nettype none
module srd_read_cdb_decoder_props (
   input wire logic mclk_i, // Clock
   input wire logic rst_i, // Reset
   input wire logic s_axi_arready_o, // Read addr ready
   input wire logic s_axi_bvalid_o, // Write resp valid
   input wire logic s_axi_bready_i, // Write resp ready
   input wire logic [31:0] s_axi_rdata_o, // Read data
   input wire logic s_axi_rvalid_o, // Read valid
   input wire logic s_axi_rready_i, // Read ready
   input wire logic xfer_valid_o, // Request valid
   input wire logic xfer_ready_i, // Request taken
   input wire logic [63:0] xfer_lba_o, // Block address
   input wire logic [31:0] xfer_count_o, // Block count
   input wire logic xfer_send_pi_o, // Send PI
   input wire logic xfer_chk_guard_o, // Guard check
   input wire logic xfer_chk_ref_o, // Ref check
   input wire logic xfer_chk_app_o, // App check
   input wire logic read_ahead_o // Read-ahead pulse
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////
   // Bus answers stand until taken
   a_bvalid_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
      else $error("write response dropped early");
   a_rdata_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read data changed while waiting");
   a_ar_blocked: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
      else $error("read address taken over pending data");
   // Request to the data path
   a_req_stable: assert property (
      xfer_valid_o && !xfer_ready_i |=> xfer_valid_o && $stable(xfer_lba_o) && $stable(xfer_count_o))
      else $error("block request changed before taken");
   a_req_once: assert property (xfer_valid_o && xfer_ready_i |=> !xfer_valid_o [*2])
      else $error("block request repeated");
   a_count_nonzero: assert property (xfer_valid_o |-> xfer_count_o != 32'h0)
      else $error("zero count sent to data path");
   a_app_off: assert property (!xfer_chk_app_o)
      else $error("application tag check enabled");
   a_check_sends_pi: assert property (xfer_valid_o && (xfer_chk_guard_o || xfer_chk_ref_o) |-> xfer_send_pi_o)
      else $error("check enabled without protection info");
   a_ahead_pulse: assert property (read_ahead_o |-> !xfer_valid_o ##1 !read_ahead_o)
      else $error("read-ahead not a single pulse");
endmodule // srd_read_cdb_decoder_props
bind srd_read_cdb_decoder srd_read_cdb_decoder_props u_props (.*);
`default_nettype wire

// *** bench/srd_datapath_model.sv ***
// Behavioural model of the block data path behind the decoder
`timescale 1ns/100ps
`default_nettype none
module srd_datapath_model (
   input wire logic mclk_i, // Clock
   input wire logic rst_i, // Async reset
   input wire logic slow_i, // Stretch accept
   input wire logic inj_guard_i, // Report guard fault
   input wire logic inj_ref_i, // Report ref fault
   input wire logic xfer_valid_i, // Request offered
   output logic xfer_ready_o, // Request taken
   output logic xfer_done_o, // Completion pulse
   output logic guard_err_o, // Guard result
   output logic ref_err_o // Ref result
);
   int cnt;
   logic busy;
   logic tog;
   ////////////////////////////////////////
   // Accept after a lag, finish four cycles later
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         xfer_ready_o <= 1'b0;
         xfer_done_o <= 1'b0;
         busy <= 1'b0;
         cnt <= 0;
         tog <= 1'b0;
      end else begin
         tog <= !tog;
         xfer_done_o <= 1'b0;
         if (xfer_ready_o && xfer_valid_i) begin
            xfer_ready_o <= 1'b0;
            busy <= 1'b1;
            cnt <= 0;
         end else if (busy) begin
            cnt <= cnt + 1;
            if (cnt == 3) begin
               xfer_done_o <= 1'b1;
               busy <= 1'b0;
               cnt <= 0;
            end
         end else if (xfer_valid_i && !xfer_ready_o) begin
            cnt <= cnt + 1;
            if (cnt >= (slow_i ? 20 : 0)) xfer_ready_o <= 1'b1;
         end
      end
   end
   // Results mean nothing outside done, so they toggle there
   assign guard_err_o = xfer_done_o ? inj_guard_i : tog;
   assign ref_err_o = xfer_done_o ? inj_ref_i : !tog;
endmodule // srd_datapath_model
`default_nettype wire

// *** bench/srd_testbench.sv ***
// Self-checking bench for the read descriptor decoder
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import srd_pkg::*;
   typedef struct {
      logic [31:0] w0, w1, w2, w3;
      logic [1:0] ctl;
      logic ig, ir, iss, ra;
      logic [11:0] st;
      logic [15:0] sn;
      logic [63:0] lba;
      logic [31:0] cnt;
      logic [15:0] fl;
   } srd_row_type;
   logic mclk = 1'b0, rst = 1'b1, slow = 1'b0, ig = 1'b0, ir = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, v, xcnt;
   logic [1:0] bresp, rresp, rsp;
   logic awready, wready, bvalid, arready, rvalid, xv, xr, xd, xg, xe, rap, sp, cg, cr, ca;
   logic [63:0] xlba, hlba;
   logic [31:0] hcnt;
   logic [3:0] hfl;
   int n_mismatch = 0, n_checks = 0, n_xfer = 0, n_ra = 0;
   // Descriptor words, ctl {ra,pifmt}, faults, issue, ra, {key,status}, sense, lba, count, flags
   srd_row_type rows [15] = '{
      '{32'hDEBCFA08, 0, 0, 0, 2'b01, 1, 1, 1, 0, 12'h000, 16'h0, 64'h1ABCDE, 32'h100, 16'h0800},
      '{32'h34123A28, 32'h7856, 5, 0, 2'b01, 0, 0, 1, 0, 12'h000, 16'h0, 64'h12345678, 5, 16'h2807},
      '{32'h4028, 0, 1, 0, 2'b01, 1, 1, 1, 0, 12'hB02, 16'h1003, 0, 1, 16'h2805},
      '{32'h6028, 0, 1, 0, 2'b01, 1, 1, 1, 0, 12'h000, 16'h0, 0, 1, 16'h2801},
      '{32'h8028, 0, 1, 0, 2'b01, 0, 1, 1, 0, 12'h000, 16'h0, 0, 1, 16'h2803},
      '{32'h2028, 0, 1, 0, 2'b01, 1, 0, 1, 0, 12'hB02, 16'h1001, 0, 1, 16'h2807},
      '{32'hBBAA00A8, 32'h0100DDCC, 0, 0, 0, 0, 0, 1, 0, 12'h0, 16'h0, 64'hAABBCCDD, 32'h10000, 16'hA800},
      '{32'h02010088, 32'h06050403, 32'h807, 32'h300, 0, 0, 0, 1, 0, 12'h0, 16'h0, 64'h0102030405060708, 3,
        16'h8800},
      '{32'hA8, 0, 0, 0, 2'b10, 0, 0, 0, 1, 12'h000, 16'h0, 0, 0, 16'h0},
      '{32'h88, 0, 0, 0, 2'b00, 0, 0, 0, 0, 12'h000, 16'h0, 0, 0, 16'h0},
      '{32'h2A, 0, 1, 0, 2'b01, 0, 0, 0, 0, 12'h502, 16'h2000, 0, 0, 16'h0},
      '{32'hA028, 0, 1, 0, 2'b01, 0, 0, 0, 0, 12'h502, 16'h2400, 0, 0, 16'h0},
      '{32'hC028, 0, 1, 0, 2'b01, 0, 0, 0, 0, 12'h502, 16'h2400, 0, 0, 16'h0},
      '{32'hE028, 0, 1, 0, 2'b01, 0, 0, 0, 0, 12'h502, 16'h2400, 0, 0, 16'h0},
      '{32'h2028, 0, 1, 0, 2'b00, 0, 0, 0, 0, 12'h502, 16'h2400, 0, 0, 16'h0}};
   ////////////////////////////////////////
   // Clock, design and data path
   always #2 mclk = ~mclk;
   srd_read_cdb_decoder u_dut (.mclk_i(mclk), .rst_i(rst), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .xfer_valid_o(xv),
      .xfer_ready_i(xr), .xfer_lba_o(xlba), .xfer_count_o(xcnt), .xfer_send_pi_o(sp), .xfer_chk_guard_o(cg),
      .xfer_chk_ref_o(cr), .xfer_chk_app_o(ca), .xfer_done_i(xd), .xfer_guard_err_i(xg), .xfer_ref_err_i(xe),
      .read_ahead_o(rap));
   srd_datapath_model u_model (.mclk_i(mclk), .rst_i(rst), .slow_i(slow), .inj_guard_i(ig), .inj_ref_i(ir),
      .xfer_valid_i(xv), .xfer_ready_o(xr), .xfer_done_o(xd), .guard_err_o(xg), .ref_err_o(xe));
   // Count handshakes and read-ahead pulses per test
   always @(posedge mclk) begin
      if (xv && xr) begin
         // Request as the data path takes it
         n_xfer++;
         hlba = xlba;
         hcnt = xcnt;
         hfl = {ca, cr, cg, sp};
      end
      if (rap) n_ra++;
   end
   ////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Both halves offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge mclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rsp = bresp; // bready stays up so back-to-back writes never toggle it in one step
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge mclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata; rsp = rresp;
   endtask
   task automatic start(input srd_row_type r);
      wr(ADDR_CDB0, r.w0); wr(ADDR_CDB1, r.w1); wr(ADDR_CDB2, r.w2); wr(ADDR_CDB3, r.w3);
      wr(ADDR_CTRL, {29'h0, r.ctl, 1'b1});
   endtask
   // Poll until done; the watchdog covers a hang
   task automatic wait_done(output logic [31:0] s);
      do rd(ADDR_STATUS, s); while (s[STAT_DONE_BIT] !== 1'b1);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #200000;
      n_mismatch++;
      complete_run();
   end
   ////////////////////////////////////////
   initial begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rd(ADDR_STATUS, v); chk("status reset", 32'h0, v);
      rd(ADDR_CTRL, v); chk("ctrl reset", 32'h0, v);
      foreach (rows[i]) begin
         ig <= rows[i].ig; ir <= rows[i].ir;
         n_xfer = 0; n_ra = 0;
         start(rows[i]);
         wait_done(v);
         chk("status", {12'h0, rows[i].st, 8'h02}, v);
         rd(ADDR_SENSE, v); chk("sense", {16'h0, rows[i].sn}, v);
         chk("transfers", {31'h0, rows[i].iss}, n_xfer);
         chk("read ahead", {31'h0, rows[i].ra}, n_ra);
         if (rows[i].iss) begin
            rd(ADDR_LBA_LO, v); chk("lba low", rows[i].lba[31:0], v);
            rd(ADDR_LBA_HI, v); chk("lba high", rows[i].lba[63:32], v);
            rd(ADDR_COUNT, v); chk("count", rows[i].cnt, v);
            rd(ADDR_FLAGS, v); chk("flags", {16'h0, rows[i].fl}, v);
            chk("req lba low", rows[i].lba[31:0], hlba[31:0]);
            chk("req lba high", rows[i].lba[63:32], hlba[63:32]);
            chk("req count", rows[i].cnt, hcnt);
            chk("req flags", {28'h0, rows[i].fl[3:0]}, {28'h0, hfl});
         end
         $display("row %0d finished", i);
      end
      // Slow data path: new descriptor and start while busy are dropped
      slow <= 1'b1; ig <= 1'b0; ir <= 1'b0; n_xfer = 0;
      start(rows[1]);
      wr(ADDR_CDB0, 32'h2A); chk("busy write resp", {30'h0, RESP_OKAY}, {30'h0, rsp});
      wr(ADDR_CTRL, 32'h1);
      wait_done(v); chk("busy status", 32'h2, v);
      rd(ADDR_FLAGS, v); chk("busy flags", 32'h2807, v);
      chk("busy transfers", 32'h1, n_xfer);
      rd(ADDR_CDB0, v); chk("busy descriptor kept", rows[1].w0, v);
      $display("busy test finished");
      // Unmapped place and read-only count
      wr(8'h2C, 32'h1); chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, rsp});
      rd(8'h2C, v); chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
      chk("unmapped data", 32'h0, v);
      wr(ADDR_COUNT, 32'hFFFFFFFF); rd(ADDR_COUNT, v); chk("count read only", 32'h5, v);
      $display("register test finished");
      // Reset in mid-command clears everything
      start(rows[6]);
      repeat (4) @(posedge mclk);
      rst <= 1'b1;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rd(ADDR_STATUS, v); chk("status after reset", 32'h0, v);
      chk("request after reset", 32'h0, {31'h0, xv});
      $display("reset test finished");
      complete_run();
   end
endmodule // testbench
`default_nettype wire
